// [lsio_pkg.sv]
// Constants, modes and pin carriers for the LCD-side I/O ports.
// Assumes an AXI4-Lite register bus with 32-bit data and one system clock.
package lsio_pkg;

  // Bus geometry.
  localparam int          ADDR_W      = 18;
  localparam int          IDX_W       = 16;
  localparam int          DATA_W      = 32;
  localparam int          WIDE_W      = 8;
  localparam int          NARROW_W    = 4;
  localparam int          SYNC_W      = WIDE_W + NARROW_W;

  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_WIDE_DATA  = 16'hFFDC;
  localparam logic [15:0] IDX_NARROW_DAT = 16'hFFDD;
  localparam logic [15:0] IDX_WIDE_DIR   = 16'hFFEC;
  localparam logic [15:0] IDX_NARROW_DIR = 16'hFFED;
  localparam logic [15:0] IDX_POWER_MODE = 16'hFFF0;

  // Reset values and fixed read patterns.
  localparam logic [7:0]  WIDE_DATA_RST  = 8'h00;
  localparam logic [7:0]  WIDE_DIR_RST   = 8'h00;
  localparam logic [7:0]  NARROW_DAT_RST = 8'hF0;
  localparam logic [7:0]  NARROW_DIR_RST = 8'hF0;
  localparam logic [7:0]  WO_READ_VAL    = 8'hFF;
  localparam logic [3:0]  NARROW_UNUSED  = 4'hF;

  // Field positions.
  localparam int          NARROW_LSB  = 0;
  localparam int          NARROW_MSB  = 3;
  localparam int          MODE_MSB    = 2;

  // AXI response codes.
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Operating modes as software writes them into the mode register.
  typedef enum logic [2:0] {
    PM_ACTIVE    = 3'h0,
    PM_SUBACTIVE = 3'h1,
    PM_SLEEP     = 3'h2,
    PM_SUBSLEEP  = 3'h3,
    PM_WATCH     = 3'h4,
    PM_STANDBY   = 3'h5
  } lsio_mode_e;

  // Pin carriers: driven level and output enable travel together.
  typedef struct packed {
    logic [WIDE_W-1:0]   out;
    logic [WIDE_W-1:0]   oe;
  } lsio_wide_s;

  typedef struct packed {
    logic [NARROW_W-1:0] out;
    logic [NARROW_W-1:0] oe;
  } lsio_narrow_s;

endpackage : lsio_pkg

// [lsio_ports.sv]
// Two chip-internal I/O ports facing the LCD controller, with AXI4-Lite
// register access. Assumes pins from the LCD side are asynchronous to
// core_clk_i and that the pad or wrapper resolves the wire from the enables.
//
// Function
// - Wide port has an 8-bit data latch holding each pin's output value.
// - Wide-port data latch clears to zero on reset.
// - Wide-port read gives latch where direction is 1, pin level where 0.
// - Wide-port direction bit 1 makes an output, 0 makes an input.
// - Wide-port direction register is write-only and reads all ones.
// - Wide-port direction register clears to zero, so all pins are inputs.
// - Wide pins float in reset and standby, work in active and subactive.
// - Wide pins keep their previous state in sleep and watch modes.
// - Narrow port holds four data bits; upper bits reset to one, value F0.
// - Narrow-port read gives latch for outputs and pin level for inputs.
// - Narrow-port direction bit 1 makes an output, 0 makes an input.
// - Narrow-port direction register resets to F0, all pins inputs.
// - Narrow-port direction register is write-only and reads all ones.
// - Narrow pins float in reset and standby, work in active and subactive.
// - Narrow pins keep previous state in sleep, subsleep and watch.
// - Narrow data decodes at index FFDD and narrow direction at FFED.
// - Wide data decodes at index FFDC and wide direction at FFEC.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps

module lsio_ports
(
  // Clock and reset
  input  wire logic                        core_clk_i,
  input  wire logic                        resetn_i,
  // AXI4-Lite write address channel
  input  wire logic                        s_axi_awvalid_i,
  output logic                             s_axi_awready_o,
  input  wire logic [lsio_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic [2:0]                  s_axi_awprot_i,
  // AXI4-Lite write data channel
  input  wire logic                        s_axi_wvalid_i,
  output logic                             s_axi_wready_o,
  input  wire logic [lsio_pkg::DATA_W-1:0] s_axi_wdata_i,
  input  wire logic [3:0]                  s_axi_wstrb_i,
  // AXI4-Lite write response channel
  output logic                             s_axi_bvalid_o,
  input  wire logic                        s_axi_bready_i,
  output logic [1:0]                       s_axi_bresp_o,
  // AXI4-Lite read address channel
  input  wire logic                        s_axi_arvalid_i,
  output logic                             s_axi_arready_o,
  input  wire logic [lsio_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic [2:0]                  s_axi_arprot_i,
  // AXI4-Lite read data channel
  output logic                             s_axi_rvalid_o,
  input  wire logic                        s_axi_rready_i,
  output logic [lsio_pkg::DATA_W-1:0]      s_axi_rdata_o,
  output logic [1:0]                       s_axi_rresp_o,
  // Wide port pins toward the LCD controller
  input  wire logic [lsio_pkg::WIDE_W-1:0]   wide_port_pins_i,
  output lsio_pkg::lsio_wide_s               wide_port_pins_o,
  // Narrow port pins toward the LCD controller
  input  wire logic [lsio_pkg::NARROW_W-1:0] narrow_port_pins_i,
  output lsio_pkg::lsio_narrow_s             narrow_port_pins_o
);

  // Write channel state machine, one-hot.
  typedef enum logic [3:0] {
    WR_IDLE = 4'h1,
    WR_ADDR = 4'h2,
    WR_DATA = 4'h4,
    WR_RESP = 4'h8
  } lsio_wr_state_e;

  function automatic logic hit_idx
  (
    input logic [lsio_pkg::ADDR_W-1:0] addr,
    input logic [lsio_pkg::IDX_W-1:0]  idx
  );
    hit_idx = (addr[lsio_pkg::ADDR_W-1:2] == idx);
  endfunction : hit_idx

  function automatic logic is_mapped
  (
    input logic [lsio_pkg::ADDR_W-1:0] addr
  );
    is_mapped = hit_idx(addr, lsio_pkg::IDX_WIDE_DATA)
             || hit_idx(addr, lsio_pkg::IDX_NARROW_DAT)
             || hit_idx(addr, lsio_pkg::IDX_WIDE_DIR)
             || hit_idx(addr, lsio_pkg::IDX_NARROW_DIR)
             || hit_idx(addr, lsio_pkg::IDX_POWER_MODE);
  endfunction : is_mapped

  // Sleep, subsleep and watch freeze the pins where they stand.
  function automatic logic mode_holds
  (
    input logic [2:0] mode
  );
    mode_holds = (mode == lsio_pkg::PM_SLEEP)
              || (mode == lsio_pkg::PM_SUBSLEEP)
              || (mode == lsio_pkg::PM_WATCH);
  endfunction : mode_holds

  // Register file.
  logic [lsio_pkg::WIDE_W-1:0]   wide_data_r;
  logic [lsio_pkg::WIDE_W-1:0]   wide_data_nxt;
  logic [lsio_pkg::WIDE_W-1:0]   wide_dir_r;
  logic [lsio_pkg::WIDE_W-1:0]   wide_dir_nxt;
  logic [lsio_pkg::NARROW_W-1:0] narrow_data_r;
  logic [lsio_pkg::NARROW_W-1:0] narrow_data_nxt;
  logic [lsio_pkg::NARROW_W-1:0] narrow_dir_r;
  logic [lsio_pkg::NARROW_W-1:0] narrow_dir_nxt;
  logic [2:0]                    mode_r;
  logic [2:0]                    mode_nxt;

  // Write channel.
  lsio_wr_state_e                wr_state_r;
  lsio_wr_state_e                wr_state_nxt;
  logic [lsio_pkg::ADDR_W-1:0]   awaddr_r;
  logic [lsio_pkg::ADDR_W-1:0]   awaddr_nxt;
  logic [lsio_pkg::DATA_W-1:0]   wdata_r;
  logic [lsio_pkg::DATA_W-1:0]   wdata_nxt;
  logic [3:0]                    wstrb_r;
  logic [3:0]                    wstrb_nxt;
  logic [1:0]                    bresp_r;
  logic [1:0]                    bresp_nxt;
  logic                          aw_hs;
  logic                          w_hs;
  logic                          wr_fire;
  logic [lsio_pkg::ADDR_W-1:0]   wr_addr;
  logic [lsio_pkg::DATA_W-1:0]   wr_data;
  logic [3:0]                    wr_strb;

  // Read channel.
  logic                          rvalid_r;
  logic                          rvalid_nxt;
  logic [lsio_pkg::DATA_W-1:0]   rdata_r;
  logic [lsio_pkg::DATA_W-1:0]   rdata_nxt;
  logic [1:0]                    rresp_r;
  logic [1:0]                    rresp_nxt;
  logic                          ar_hs;

  // Pin input synchroniser and pin drivers.
  logic [lsio_pkg::SYNC_W-1:0]   sync1_r;
  logic [lsio_pkg::SYNC_W-1:0]   sync2_r;
  logic [lsio_pkg::SYNC_W-1:0]   sync3_r;
  logic [lsio_pkg::SYNC_W-1:0]   pin_lvl_r;
  logic [lsio_pkg::SYNC_W-1:0]   pin_lvl_nxt;
  lsio_pkg::lsio_wide_s          wide_drv_r;
  lsio_pkg::lsio_wide_s          wide_drv_nxt;
  lsio_pkg::lsio_narrow_s        narrow_drv_r;
  lsio_pkg::lsio_narrow_s        narrow_drv_nxt;
  logic [lsio_pkg::WIDE_W-1:0]   wide_lvl;
  logic [lsio_pkg::NARROW_W-1:0] narrow_lvl;

  assign aw_hs = s_axi_awvalid_i && s_axi_awready_o;
  assign w_hs  = s_axi_wvalid_i && s_axi_wready_o;
  assign ar_hs = s_axi_arvalid_i && s_axi_arready_o;

  assign wide_lvl   = pin_lvl_r[lsio_pkg::SYNC_W-1:lsio_pkg::NARROW_W];
  assign narrow_lvl = pin_lvl_r[lsio_pkg::NARROW_W-1:0];

  // Address and data are accepted in either order; the write lands when
  // the later of the two arrives, and bvalid rises on that same edge.
  always_comb
  begin
    wr_state_nxt    = wr_state_r;
    awaddr_nxt      = awaddr_r;
    wdata_nxt       = wdata_r;
    wstrb_nxt       = wstrb_r;
    s_axi_awready_o = 1'b0;
    s_axi_wready_o  = 1'b0;
    wr_fire         = 1'b0;
    case (wr_state_r)
      WR_IDLE:
      begin
        s_axi_awready_o = 1'b1;
        s_axi_wready_o  = 1'b1;
        if (aw_hs && w_hs)
        begin
          wr_fire      = 1'b1;
          wr_state_nxt = WR_RESP;
        end
        else if (aw_hs)
        begin
          wr_state_nxt = WR_ADDR;
        end
        else if (w_hs)
        begin
          wr_state_nxt = WR_DATA;
        end
      end
      WR_ADDR:
      begin
        s_axi_wready_o = 1'b1;
        if (w_hs)
        begin
          wr_fire      = 1'b1;
          wr_state_nxt = WR_RESP;
        end
      end
      WR_DATA:
      begin
        s_axi_awready_o = 1'b1;
        if (aw_hs)
        begin
          wr_fire      = 1'b1;
          wr_state_nxt = WR_RESP;
        end
      end
      WR_RESP:
      begin
        if (s_axi_bready_i)
        begin
          wr_state_nxt = WR_IDLE;
        end
      end
      default:
      begin
        wr_state_nxt = WR_IDLE;
      end
    endcase
    if (aw_hs)
    begin
      awaddr_nxt = s_axi_awaddr_i;
    end
    if (w_hs)
    begin
      wdata_nxt = s_axi_wdata_i;
      wstrb_nxt = s_axi_wstrb_i;
    end
  end

  assign wr_addr = aw_hs ? s_axi_awaddr_i : awaddr_r;
  assign wr_data = w_hs ? s_axi_wdata_i : wdata_r;
  assign wr_strb = w_hs ? s_axi_wstrb_i : wstrb_r;

  // Register writes. Every register lives in byte lane 0, so a write with
  // wstrb[0] low is answered OKAY at a mapped index but changes nothing.
  always_comb
  begin
    wide_data_nxt   = wide_data_r;
    wide_dir_nxt    = wide_dir_r;
    narrow_data_nxt = narrow_data_r;
    narrow_dir_nxt  = narrow_dir_r;
    mode_nxt        = mode_r;
    bresp_nxt       = bresp_r;
    if (wr_fire)
    begin
      bresp_nxt = is_mapped(wr_addr) ? lsio_pkg::RESP_OKAY
                                     : lsio_pkg::RESP_SLVERR;
      if (!wr_strb[0])
      begin
        // Without byte lane 0 the write is answered but lands nowhere.
        wide_data_nxt = wide_data_r;
      end
      else if (hit_idx(wr_addr, lsio_pkg::IDX_WIDE_DATA))
      begin
        wide_data_nxt = wr_data[lsio_pkg::WIDE_W-1:0];
      end
      else if (hit_idx(wr_addr, lsio_pkg::IDX_WIDE_DIR))
      begin
        wide_dir_nxt = wr_data[lsio_pkg::WIDE_W-1:0];
      end
      else if (hit_idx(wr_addr, lsio_pkg::IDX_NARROW_DAT))
      begin
        narrow_data_nxt =
          wr_data[lsio_pkg::NARROW_MSB:lsio_pkg::NARROW_LSB];
      end
      else if (hit_idx(wr_addr, lsio_pkg::IDX_NARROW_DIR))
      begin
        narrow_dir_nxt =
          wr_data[lsio_pkg::NARROW_MSB:lsio_pkg::NARROW_LSB];
      end
      else if (hit_idx(wr_addr, lsio_pkg::IDX_POWER_MODE))
      begin
        mode_nxt = wr_data[lsio_pkg::MODE_MSB:0];
      end
    end
  end

  // Reads: one read in flight; arready drops while the answer waits.
  always_comb
  begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rvalid_r && s_axi_rready_i)
    begin
      rvalid_nxt = 1'b0;
    end
    if (ar_hs)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = '0;
      rresp_nxt  = lsio_pkg::RESP_OKAY;
      if (hit_idx(s_axi_araddr_i, lsio_pkg::IDX_WIDE_DATA))
      begin
        rdata_nxt[lsio_pkg::WIDE_W-1:0] =
          (wide_data_r & wide_dir_r) | (wide_lvl & ~wide_dir_r);
      end
      else if (hit_idx(s_axi_araddr_i, lsio_pkg::IDX_WIDE_DIR))
      begin
        rdata_nxt[7:0] = lsio_pkg::WO_READ_VAL;
      end
      else if (hit_idx(s_axi_araddr_i, lsio_pkg::IDX_NARROW_DAT))
      begin
        rdata_nxt[7:0] = {lsio_pkg::NARROW_UNUSED,
                          (narrow_data_r & narrow_dir_r)
                          | (narrow_lvl & ~narrow_dir_r)};
      end
      else if (hit_idx(s_axi_araddr_i, lsio_pkg::IDX_NARROW_DIR))
      begin
        rdata_nxt[7:0] = lsio_pkg::WO_READ_VAL;
      end
      else if (hit_idx(s_axi_araddr_i, lsio_pkg::IDX_POWER_MODE))
      begin
        rdata_nxt[lsio_pkg::MODE_MSB:0] = mode_r;
      end
      else
      begin
        rresp_nxt = lsio_pkg::RESP_SLVERR;
      end
    end
  end

  assign s_axi_arready_o = !rvalid_r;
  assign s_axi_rvalid_o  = rvalid_r;
  assign s_axi_rdata_o   = rdata_r;
  assign s_axi_rresp_o   = rresp_r;
  assign s_axi_bvalid_o  = (wr_state_r == WR_RESP);
  assign s_axi_bresp_o   = bresp_r;

  // A pin change is taken only once the second and third stages agree, so
  // a level caught mid-transition is never reported.
  always_comb
  begin
    pin_lvl_nxt = pin_lvl_r;
    for (int i = 0; i < lsio_pkg::SYNC_W; i++)
    begin
      if (sync2_r[i] == sync3_r[i])
      begin
        pin_lvl_nxt[i] = sync3_r[i];
      end
    end
  end

  // Pin drivers follow the latches in active, subactive and the unused mode codes 6 and 7.
  // Standby floats them; the sleep family freezes them even if software writes.
  always_comb
  begin
    wide_drv_nxt   = wide_drv_r;
    narrow_drv_nxt = narrow_drv_r;
    if (mode_r == lsio_pkg::PM_STANDBY)
    begin
      wide_drv_nxt.oe   = '0;
      narrow_drv_nxt.oe = '0;
    end
    else if (mode_holds(mode_r))
    begin
      wide_drv_nxt   = wide_drv_r;
      narrow_drv_nxt = narrow_drv_r;
    end
    else
    begin
      wide_drv_nxt.out   = wide_data_r;
      wide_drv_nxt.oe    = wide_dir_r;
      narrow_drv_nxt.out = narrow_data_r;
      narrow_drv_nxt.oe  = narrow_dir_r;
    end
  end

  // Enables are also gated by reset so pins float from the first moment
  // reset is seen, not only after the next edge.
  assign wide_port_pins_o.out   = wide_drv_r.out;
  assign wide_port_pins_o.oe    = wide_drv_r.oe & {lsio_pkg::WIDE_W{resetn_i}};
  assign narrow_port_pins_o.out = narrow_drv_r.out;
  assign narrow_port_pins_o.oe  =
    narrow_drv_r.oe & {lsio_pkg::NARROW_W{resetn_i}};

  always_ff @(posedge core_clk_i)
  begin
    sync1_r <= {wide_port_pins_i, narrow_port_pins_i};
    sync2_r <= sync1_r;
    sync3_r <= sync2_r;
    if (!resetn_i)
    begin
      wide_data_r   <= lsio_pkg::WIDE_DATA_RST;
      wide_dir_r    <= lsio_pkg::WIDE_DIR_RST;
      narrow_data_r <= lsio_pkg::NARROW_DAT_RST[3:0];
      narrow_dir_r  <= lsio_pkg::NARROW_DIR_RST[3:0];
      mode_r        <= lsio_pkg::PM_ACTIVE;
      wr_state_r    <= WR_IDLE;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
      bresp_r       <= lsio_pkg::RESP_OKAY;
      rvalid_r      <= 1'b0;
      rdata_r       <= '0;
      rresp_r       <= lsio_pkg::RESP_OKAY;
      pin_lvl_r     <= '0;
      wide_drv_r    <= '0;
      narrow_drv_r  <= '0;
    end
    else
    begin
      wide_data_r   <= wide_data_nxt;
      wide_dir_r    <= wide_dir_nxt;
      narrow_data_r <= narrow_data_nxt;
      narrow_dir_r  <= narrow_dir_nxt;
      mode_r        <= mode_nxt;
      wr_state_r    <= wr_state_nxt;
      awaddr_r      <= awaddr_nxt;
      wdata_r       <= wdata_nxt;
      wstrb_r       <= wstrb_nxt;
      bresp_r       <= bresp_nxt;
      rvalid_r      <= rvalid_nxt;
      rdata_r       <= rdata_nxt;
      rresp_r       <= rresp_nxt;
      pin_lvl_r     <= pin_lvl_nxt;
      wide_drv_r    <= wide_drv_nxt;
      narrow_drv_r  <= narrow_drv_nxt;
    end
  end

  AST_RESET_VALUES : assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    $past(!resetn_i) |-> (wide_data_r == 8'h00) && (wide_dir_r == 8'h00)
                         && (narrow_dir_r == 4'h0) && !s_axi_bvalid_o)
    else $error("Registers not at reset values after reset release.");

  AST_WIDE_WRITE : assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    (wr_fire && wr_strb[0] && hit_idx(wr_addr, lsio_pkg::IDX_WIDE_DATA))
    |=> (wide_data_r == $past(wr_data[7:0])) && s_axi_bvalid_o)
    else $error("Wide data write did not land in the latch.");

  AST_NARROW_DIR_WRITE : assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    (wr_fire && wr_strb[0] && hit_idx(wr_addr, lsio_pkg::IDX_NARROW_DIR))
    |=> (narrow_dir_r == $past(wr_data[3:0])))
    else $error("Narrow direction write did not land.");

  AST_WIDE_READ_MIX : assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    (ar_hs && hit_idx(s_axi_araddr_i, lsio_pkg::IDX_WIDE_DATA))
    |=> s_axi_rvalid_o && (s_axi_rdata_o[7:0] ==
        (($past(wide_data_r) & $past(wide_dir_r))
         | ($past(wide_lvl) & ~$past(wide_dir_r)))))
    else $error("Wide port read mixes latch and pins wrongly.");

  AST_DIR_READS_ONES : assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    (ar_hs && (hit_idx(s_axi_araddr_i, lsio_pkg::IDX_WIDE_DIR)
               || hit_idx(s_axi_araddr_i, lsio_pkg::IDX_NARROW_DIR)))
    |=> s_axi_rvalid_o && (s_axi_rdata_o[7:0] == 8'hFF))
    else $error("Direction register did not read as all ones.");

  AST_NARROW_UPPER_ONES : assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    (ar_hs && hit_idx(s_axi_araddr_i, lsio_pkg::IDX_NARROW_DAT))
    |=> (s_axi_rdata_o[7:4] == 4'hF) && (s_axi_rdata_o[3:0] ==
        (($past(narrow_data_r) & $past(narrow_dir_r))
         | ($past(narrow_lvl) & ~$past(narrow_dir_r)))))
    else $error("Narrow port read has wrong upper or data bits.");

  AST_ACTIVE_DRIVE : assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    ((mode_r == lsio_pkg::PM_ACTIVE) && $stable(mode_r))
    |-> (wide_port_pins_o.oe == $past(wide_dir_r))
        && (wide_port_pins_o.out == $past(wide_data_r))
        && (narrow_port_pins_o.oe == $past(narrow_dir_r)))
    else $error("Active pins do not follow latch and direction.");

  AST_STANDBY_FLOAT : assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    $past(mode_r == lsio_pkg::PM_STANDBY)
    |-> (wide_port_pins_o.oe == 8'h00) && (narrow_port_pins_o.oe == 4'h0))
    else $error("Pins driven while in standby.");

  AST_HOLD_FREEZE : assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    ($past(mode_holds(mode_r)) && $past(resetn_i))
    |-> $stable(wide_port_pins_o) && $stable(narrow_port_pins_o))
    else $error("Pins changed while held in a sleep mode.");

endmodule : lsio_ports

// [lsio_lcd_model.sv]
// Behavioural LCD-side partner of the two I/O ports.
// Assumes the bench sets the levels that the LCD side drives.
`timescale 1ns/100ps

module lsio_lcd_model
(
  // Design drivers
  input  wire lsio_pkg::lsio_wide_s   wide_pins_i,
  input  wire lsio_pkg::lsio_narrow_s narrow_pins_i,
  // Levels offered by the LCD side
  input  wire logic [7:0]             lcd_wide_i,
  input  wire logic [3:0]             lcd_narrow_i,
  // Resolved wire levels
  output logic [7:0]                  wide_lvl_o,
  output logic [3:0]                  narrow_lvl_o
);
  // The LCD side yields wherever the port drives, so no line floats.
  assign wide_lvl_o = (wide_pins_i.oe & wide_pins_i.out)
                    | (~wide_pins_i.oe & lcd_wide_i);
  assign narrow_lvl_o = (narrow_pins_i.oe & narrow_pins_i.out)
                      | (~narrow_pins_i.oe & lcd_narrow_i);
endmodule : lsio_lcd_model

// [tb_top.sv]
// Self-checking bench for the LCD-side I/O ports.
// Assumes the LCD partner model resolves the pin wires.
`timescale 1ns/100ps

module tb_top;
  logic                   clk     = 1'b0;
  logic                   rstn    = 1'b0;
  logic                   awv     = 1'b0;
  logic                   wv      = 1'b0;
  logic                   bry     = 1'b0;
  logic                   arv     = 1'b0;
  logic                   rry     = 1'b0;
  logic [17:0]            awa     = 18'h0_0000;
  logic [17:0]            ara     = 18'h0_0000;
  logic [31:0]            wd      = 32'h0000_0000;
  logic [3:0]             ws      = 4'h0;
  logic [7:0]             lcd_w   = 8'h5A;
  logic [3:0]             lcd_n   = 4'h9;
  logic                   awrdy;
  logic                   wrdy;
  logic                   bv;
  logic                   arrdy;
  logic                   rv;
  logic [1:0]             br;
  logic [1:0]             rr;
  logic [31:0]            rdat;
  logic [7:0]             wlv;
  logic [3:0]             nlv;
  lsio_pkg::lsio_wide_s   wpo;
  lsio_pkg::lsio_narrow_s npo;
  int                     n_fail  = 0;
  int                     n_tests = 0;

  lsio_ports lsio_ports_i
  (
    .core_clk_i(clk), .resetn_i(rstn),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awrdy),
    .s_axi_awaddr_i(awa), .s_axi_awprot_i(3'h0),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_bresp_o(br),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arrdy),
    .s_axi_araddr_i(ara), .s_axi_arprot_i(3'h0),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
    .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr),
    .wide_port_pins_i(wlv), .wide_port_pins_o(wpo),
    .narrow_port_pins_i(nlv), .narrow_port_pins_o(npo)
  );

  lsio_lcd_model lsio_lcd_model_i
  (
    .wide_pins_i(wpo), .narrow_pins_i(npo),
    .lcd_wide_i(lcd_w), .lcd_narrow_i(lcd_n),
    .wide_lvl_o(wlv), .narrow_lvl_o(nlv)
  );

  initial
  begin
    forever #5 clk = ~clk;
  end

  task automatic test_done;
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Address and data are offered together and each is dropped when taken.
  task automatic wr_reg(input logic [15:0] idx, input logic [7:0] d,
    input logic [3:0] s = 4'h1,
    input logic [1:0] er = lsio_pkg::RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk);
    awa <= {idx, 2'b00};
    wd <= {24'h00_0000, d};
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 50);
    bry <= 1'b0;
    if (n >= 50) n_fail++;
    chk(br, er);
  endtask : wr_reg

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp,
    input logic [1:0] er = lsio_pkg::RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk);
    ara <= {idx, 2'b00};
    arv <= 1'b1;
    rry <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arrdy) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 50);
    rry <= 1'b0;
    if (n >= 50) n_fail++;
    chk(rdat, exp);
    chk(rr, er);
  endtask : rd_chk

  // Values seen just after a reset, with the LCD side offering 5A and 9.
  task automatic t_reset;
    chk(wpo.oe, 8'h00);
    chk(npo.oe, 4'h0);
    rd_chk(lsio_pkg::IDX_WIDE_DIR, 8'hFF);
    rd_chk(lsio_pkg::IDX_NARROW_DIR, 8'hFF);
    repeat (6) @(posedge clk);
    rd_chk(lsio_pkg::IDX_WIDE_DATA, 8'h5A);
    rd_chk(lsio_pkg::IDX_NARROW_DAT, 8'hF9);
    wr_reg(lsio_pkg::IDX_WIDE_DIR, 8'hFF);
    wr_reg(lsio_pkg::IDX_NARROW_DIR, 8'h0F);
    rd_chk(lsio_pkg::IDX_WIDE_DATA, 8'h00);
    rd_chk(lsio_pkg::IDX_NARROW_DAT, 8'hF0);
  endtask : t_reset

  task automatic t_wide;
    wr_reg(lsio_pkg::IDX_WIDE_DIR, 8'h0F);
    wr_reg(lsio_pkg::IDX_WIDE_DATA, 8'hA5);
    lcd_w <= 8'h3C;
    wr_reg(lsio_pkg::IDX_WIDE_DATA, 8'h00, 4'h0);
    repeat (6) @(posedge clk);
    rd_chk(lsio_pkg::IDX_WIDE_DATA, 8'h35);
    chk(wpo.oe, 8'h0F);
    chk(wpo.out, 8'hA5);
    chk(wlv, 8'h35);
    wr_reg(16'h0000, 8'h77, 4'h1, lsio_pkg::RESP_SLVERR);
    rd_chk(16'h0000, 32'h0000_0000, lsio_pkg::RESP_SLVERR);
  endtask : t_wide

  // Upper narrow bits written as zero must still read as ones.
  task automatic t_narrow;
    wr_reg(lsio_pkg::IDX_NARROW_DIR, 8'h03);
    wr_reg(lsio_pkg::IDX_NARROW_DAT, 8'h0A);
    lcd_n <= 4'h4;
    repeat (6) @(posedge clk);
    rd_chk(lsio_pkg::IDX_NARROW_DAT, 8'hF6);
    rd_chk(lsio_pkg::IDX_NARROW_DIR, 8'hFF);
    chk(npo.oe, 4'h3);
    chk(nlv, 4'h6);
  endtask : t_narrow

  // Walks every mode; pins keep the last value of an active mode.
  task automatic t_modes;
    logic [7:0] m;
    logic [7:0] d;
    logic [7:0] ew;
    wr_reg(lsio_pkg::IDX_WIDE_DIR, 8'hFF);
    wr_reg(lsio_pkg::IDX_NARROW_DIR, 8'h0F);
    for (int i = 0; i < 7; i++)
    begin
      m = (i == 6) ? 8'h00 : 8'(i);
      d = 8'h11 * 8'(i + 1);
      wr_reg(lsio_pkg::IDX_POWER_MODE, m);
      wr_reg(lsio_pkg::IDX_WIDE_DATA, d);
      wr_reg(lsio_pkg::IDX_NARROW_DAT, {4'h0, d[3:0]});
      if (m < 8'h02) ew = d;
      repeat (2) @(posedge clk);
      rd_chk(lsio_pkg::IDX_WIDE_DATA, d);
      rd_chk(lsio_pkg::IDX_POWER_MODE, {24'h00_0000, m});
      if (m == 8'h05)
        chk({wpo.oe, npo.oe}, 12'h000);
      else
      begin
        chk(wpo.out, ew);
        chk(npo.out, ew[3:0]);
      end
    end
  endtask : t_modes

  task automatic t_rst_mid;
    lcd_w <= 8'h5A;
    lcd_n <= 4'h9;
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    #1;
    chk({wpo.oe, npo.oe}, 12'h000);
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
  endtask : t_rst_mid

  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_wide();
    t_narrow();
    t_modes();
    t_rst_mid();
    test_done();
  end

  // The sequence needs well under two thousand cycles.
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done();
  end
endmodule : tb_top
